// >>> qbpl_board.sv
`timescale 1ns/1ns
module qbpl_board
   import qbpl_pkg::*;
(
   input  wire logic [EIGHT_W-1:0] oe8_i,
   input  wire logic [EIGHT_W-1:0] ext_low8_i,
   input  wire logic [FIVE_W-1:0]  oe5_i,
   input  wire logic [FIVE_W-1:0]  ext_low5_i,
   output logic      [EIGHT_W-1:0] pin8_o,
   output logic      [FIVE_W-1:0]  pin5_o
);
   // wired-and line: released lines rest at the pull-up level, never a stale value
   assign pin8_o = ~(oe8_i | ext_low8_i);
   assign pin5_o = ~(oe5_i | ext_low5_i);
endmodule

// >>> qbpl_line_if.sv
`timescale 1ns/1ns
interface qbpl_line_if #(parameter int unsigned W = 8);
   logic [W-1:0] latch;
   logic [W-1:0] alt_out;
   logic [W-1:0] pin_in;
   logic [W-1:0] pin_sampled;
   logic [W-1:0] drive_low;
   modport port_side (output latch, output alt_out, output pin_in,
                      input pin_sampled, input drive_low);
   modport line_side (input latch, input alt_out, input pin_in,
                      output pin_sampled, output drive_low);
endinterface

// >>> qbpl_lines.sv
`timescale 1ns/1ns
module qbpl_lines
   import qbpl_pkg::*;
#(
   parameter int unsigned W = 8
)(
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   qbpl_line_if.line_side lif
);
   logic [W-1:0] drive_low_ff;
   logic [W-1:0] nxt_drive_low;
   logic [W-1:0] sampled_ff;
   logic [W-1:0] nxt_sampled;

   // registered drive: pin follows latch one cycle later, like the real buffer
   genvar g;
   for (g = 0; g < W; g++) begin : g_line
      always_comb begin
         nxt_drive_low[g] = ~(lif.latch[g] & lif.alt_out[g]);
         nxt_sampled[g]   = lif.pin_in[g];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         drive_low_ff <= '0;
         sampled_ff   <= '0;
      end else begin
         drive_low_ff <= nxt_drive_low;
         sampled_ff   <= nxt_sampled;
      end
   end

   assign lif.drive_low   = drive_low_ff;
   assign lif.pin_sampled = sampled_ff;

   AST_DRIVE_FOLLOWS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !$past(rst_i) |-> lif.drive_low == ~($past(lif.latch) & $past(lif.alt_out)))
      else $error("drive does not follow latch and alternate");
   AST_SAMPLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !$past(rst_i) |-> lif.pin_sampled == $past(lif.pin_in))
      else $error("pin sample wrong");
endmodule

// >>> qbpl_pkg.sv
// Function
// - eight-line port pulls up lines latched one
// - alternates need latch one, except transmit/write
// - five-line port pulls up lines latched one
// - can receive passes only when latch set
// - eight-line port alternate function bit routing
// - five-line port alternate function bit routing
// - serial receive bidirectional, transmit clocks synchronously
// - write and read strobes drive external memory
// - write strobe loads bus into latches
// - read-latch strobe returns latch contents
// - read-pin strobe returns sampled pin levels
// - every line independently input or output, except transmit and write strobe
// - reset forces every latch to one
// - set latch lets alternate output drive
// - latch changes late, pin updates next
package qbpl_pkg;
   localparam int unsigned EIGHT_W  = 8;
   localparam int unsigned FIVE_W   = 5;
   localparam logic [7:0]  EIGHT_RST = 8'hff;
   localparam logic [4:0]  FIVE_RST  = 5'h1f;
   // eight-line port bit positions
   localparam int unsigned B_RXD  = 0;
   localparam int unsigned B_TXD  = 1;
   localparam int unsigned B_INTA = 2;
   localparam int unsigned B_INTB = 3;
   localparam int unsigned B_TMA  = 4;
   localparam int unsigned B_TMB  = 5;
   localparam int unsigned B_WRS  = 6;
   localparam int unsigned B_RDS  = 7;
   // five-line port bit positions
   localparam int unsigned B_CTX  = 0;
   localparam int unsigned B_CRX  = 1;
   localparam int unsigned B_MISO = 2;
   localparam int unsigned B_SCK  = 3;
   localparam int unsigned B_MOSI = 4;
   localparam logic [1:0]  SEL_EIGHT = 2'h0;
   localparam logic [1:0]  SEL_FIVE  = 2'h1;
endpackage

// >>> qbpl_ports.sv
`timescale 1ns/1ns
module qbpl_ports
   import qbpl_pkg::*;
(
   input  wire logic                sys_clk_i,
   input  wire logic                rst_i,
   // cpu side
   input  wire logic [1:0]          port_sel_i,
   input  wire logic                wr_latch_i,
   input  wire logic                rd_latch_i,
   input  wire logic                rd_pin_i,
   input  wire logic [7:0]          bus_wdata_i,
   output logic      [7:0]          bus_rdata_o,
   // eight-line port pins (open drain low, pull-up high)
   input  wire logic [EIGHT_W-1:0]  eight_line_port_in_i,
   output logic      [EIGHT_W-1:0]  eight_line_port_out_o,
   output logic      [EIGHT_W-1:0]  eight_line_port_oe_o,
   output logic      [EIGHT_W-1:0]  eight_line_port_pullup_o,
   // five-line port pins
   input  wire logic [FIVE_W-1:0]   five_line_port_in_i,
   output logic      [FIVE_W-1:0]   five_line_port_out_o,
   output logic      [FIVE_W-1:0]   five_line_port_oe_o,
   output logic      [FIVE_W-1:0]   five_line_port_pullup_o,
   // serial port
   input  wire logic                uart_sync_mode_i,
   input  wire logic                uart_rxd_out_i,
   input  wire logic                uart_txd_out_i,
   output logic                     uart_rxd_o,
   // interrupts, timers and spi select
   output logic                     ext_interrupt_a_o,
   output logic                     ext_interrupt_b_o,
   output logic                     timer_a_count_in_o,
   output logic                     timer_b_count_in_o,
   output logic                     spi_ss_o,
   // external data memory strobes, active low
   input  wire logic                xmem_wr_n_i,
   input  wire logic                xmem_rd_n_i,
   // can and spi
   input  wire logic                can_transmit_out_i,
   output logic                     can_receive_in_o,
   input  wire logic                spi_miso_out_i,
   output logic                     spi_miso_o,
   input  wire logic                spi_sck_out_i,
   output logic                     spi_sck_o,
   input  wire logic                spi_mosi_out_i,
   output logic                     spi_mosi_o
);
   logic [EIGHT_W-1:0] eight_ff;
   logic [EIGHT_W-1:0] nxt_eight;
   logic [FIVE_W-1:0]  five_ff;
   logic [FIVE_W-1:0]  nxt_five;
   logic [7:0]         rdata_ff;
   logic [7:0]         nxt_rdata;
   logic [EIGHT_W-1:0] eight_alt;
   logic [FIVE_W-1:0]  five_alt;

   qbpl_line_if #(.W(EIGHT_W)) e_if ();
   qbpl_line_if #(.W(FIVE_W))  f_if ();

   // latch write: one cycle, so a rmw sequence lands at its end
   always_comb begin
      nxt_eight = eight_ff;
      nxt_five  = five_ff;
      if (wr_latch_i && port_sel_i == SEL_EIGHT) begin
         nxt_eight = bus_wdata_i;
      end
      if (wr_latch_i && port_sel_i == SEL_FIVE) begin
         nxt_five = bus_wdata_i[FIVE_W-1:0];
      end
   end

   // read mux; latch read takes priority, core must pick it for rmw
   always_comb begin
      nxt_rdata = 8'h00;
      if (rd_latch_i) begin
         unique case (port_sel_i)
            SEL_EIGHT: nxt_rdata = eight_ff;
            SEL_FIVE:  nxt_rdata = {3'h0, five_ff};
            default:   nxt_rdata = 8'h00;
         endcase
      end else if (rd_pin_i) begin
         unique case (port_sel_i)
            SEL_EIGHT: nxt_rdata = e_if.pin_sampled;
            SEL_FIVE:  nxt_rdata = {3'h0, f_if.pin_sampled};
            default:   nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         eight_ff <= EIGHT_RST;
         five_ff  <= FIVE_RST;
         rdata_ff <= 8'h00;
      end else begin
         eight_ff <= nxt_eight;
         five_ff  <= nxt_five;
         rdata_ff <= nxt_rdata;
      end
   end
   assign bus_rdata_o = rdata_ff;

   // alternate outputs; lines without an output function idle high
   always_comb begin
      eight_alt         = '1;
      eight_alt[B_RXD]  = uart_sync_mode_i ? uart_rxd_out_i : 1'b1;
      eight_alt[B_WRS]  = xmem_wr_n_i;
      eight_alt[B_RDS]  = xmem_rd_n_i;
      five_alt          = '1;
      five_alt[B_CTX]   = can_transmit_out_i;
      five_alt[B_MISO]  = spi_miso_out_i;
      five_alt[B_SCK]   = spi_sck_out_i;
      five_alt[B_MOSI]  = spi_mosi_out_i;
   end

   assign e_if.latch   = eight_ff;
   assign e_if.alt_out = eight_alt;
   assign e_if.pin_in  = eight_line_port_in_i;
   assign f_if.latch   = five_ff;
   assign f_if.alt_out = five_alt;
   assign f_if.pin_in  = five_line_port_in_i;

   // transmit and write strobe bypass the latch, so they override it here
   always_comb begin
      eight_line_port_oe_o = e_if.drive_low;
      eight_line_port_oe_o[B_TXD] = ~uart_txd_out_i;
      eight_line_port_oe_o[B_WRS] = ~xmem_wr_n_i;
   end
   qbpl_lines #(.W(EIGHT_W)) u_eight (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .lif       (e_if)
   );
   qbpl_lines #(.W(FIVE_W)) u_five (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .lif       (f_if)
   );

   assign eight_line_port_out_o    = '0;
   assign eight_line_port_pullup_o = eight_ff;
   assign five_line_port_out_o     = '0;
   assign five_line_port_oe_o      = f_if.drive_low;
   assign five_line_port_pullup_o  = five_ff;

   // inputs gated by latch, five-line spi ones ungated: a cleared latch holds the input inactive, high, or low for both timer count inputs
   assign uart_rxd_o         = e_if.pin_sampled[B_RXD] | ~eight_ff[B_RXD];
   assign ext_interrupt_a_o  = e_if.pin_sampled[B_INTA] | ~eight_ff[B_INTA];
   assign ext_interrupt_b_o  = e_if.pin_sampled[B_INTB] | ~eight_ff[B_INTB];
   assign timer_a_count_in_o = e_if.pin_sampled[B_TMA] & eight_ff[B_TMA];
   assign timer_b_count_in_o = e_if.pin_sampled[B_TMB] & eight_ff[B_TMB];
   assign spi_ss_o           = e_if.pin_sampled[B_TMB] | ~eight_ff[B_TMB];
   assign can_receive_in_o   = f_if.pin_sampled[B_CRX] | ~five_ff[B_CRX];
   assign spi_miso_o         = f_if.pin_sampled[B_MISO];
   assign spi_sck_o          = f_if.pin_sampled[B_SCK];
   assign spi_mosi_o         = f_if.pin_sampled[B_MOSI];

   // reset judged one edge later, so no value from before the first edge is used
   AST_RESET_ONES: assert property (@(posedge sys_clk_i)
      rst_i |=> eight_ff == EIGHT_RST && five_ff == FIVE_RST)
      else $error("latches not one after reset");

   // cpu side
   AST_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_latch_i && port_sel_i == SEL_EIGHT |=> eight_ff == $past(bus_wdata_i))
      else $error("latch write lost");
   AST_WR_REFUSED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_latch_i && port_sel_i[1] |=> $stable(eight_ff) && $stable(five_ff))
      else $error("unmapped write changed a latch");
   AST_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !wr_latch_i |=> $stable(eight_ff) && $stable(five_ff))
      else $error("latch changed without a write");
   AST_RD_LATCH: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_latch_i && port_sel_i == SEL_EIGHT |=> bus_rdata_o == $past(eight_ff))
      else $error("latch read wrong");
   AST_RD_LATCH5: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_latch_i && port_sel_i == SEL_FIVE |=> bus_rdata_o == {3'h0, $past(five_ff)})
      else $error("five-line latch read wrong");
   AST_RD_PIN: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      rd_pin_i && !rd_latch_i && port_sel_i == SEL_EIGHT
      |=> bus_rdata_o == $past(e_if.pin_sampled))
      else $error("pin read wrong");
   AST_RD_IDLE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!rd_latch_i && !rd_pin_i) || port_sel_i[1] |=> bus_rdata_o == 8'h00)
      else $error("read data not zero without a mapped read");

   // peripheral inputs
   AST_CAN_GATE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !five_ff[B_CRX] |-> can_receive_in_o)
      else $error("can receive passed with latch clear");
   AST_CAN_PASS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      five_ff[B_CRX] |-> can_receive_in_o == f_if.pin_sampled[B_CRX])
      else $error("can receive lost with latch set");
   AST_ALT_GATE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (eight_ff[B_RXD] || uart_rxd_o) && (eight_ff[B_INTA] || ext_interrupt_a_o)
      && (eight_ff[B_INTB] || ext_interrupt_b_o)
      && (eight_ff[B_TMA] || !timer_a_count_in_o)
      && (eight_ff[B_TMB] || (!timer_b_count_in_o && spi_ss_o)))
      else $error("alternate input active with latch clear");
   AST_TIMER_PASS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      eight_ff[B_TMA] |-> timer_a_count_in_o == e_if.pin_sampled[B_TMA])
      else $error("timer count input not routed");
   AST_SS_PASS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      eight_ff[B_TMB] |-> spi_ss_o == e_if.pin_sampled[B_TMB]
      && timer_b_count_in_o == e_if.pin_sampled[B_TMB])
      else $error("shared select line not routed");

   // pin side
   AST_PULLUP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_latch_i && port_sel_i == SEL_EIGHT |=> eight_line_port_pullup_o == $past(bus_wdata_i))
      else $error("pull-up does not follow written latch");
   AST_PULLUP5: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_latch_i && port_sel_i == SEL_FIVE
      |=> five_line_port_pullup_o == $past(bus_wdata_i[FIVE_W-1:0]))
      else $error("five-line pull-up does not follow written latch");
   AST_PIN_LAG: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_latch_i && port_sel_i == SEL_FIVE && bus_wdata_i[B_MOSI] == 1'b0
      |=> ##1 five_line_port_oe_o[B_MOSI])
      else $error("pin did not follow cleared latch");
   AST_PIN_RISE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      wr_latch_i && port_sel_i == SEL_FIVE && bus_wdata_i[B_CRX]
      |=> ##1 !five_line_port_oe_o[B_CRX])
      else $error("pin not released after latch set");
   AST_RDS_ALT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      eight_ff[B_RDS] |=> eight_line_port_oe_o[B_RDS] == !$past(xmem_rd_n_i))
      else $error("read strobe not on pin");
   AST_RXD_MODE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      eight_ff[B_RXD]
      |=> eight_line_port_oe_o[B_RXD] == ($past(uart_sync_mode_i) && !$past(uart_rxd_out_i)))
      else $error("receive line drive wrong for serial mode");
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb;
   import qbpl_pkg::*;
   logic       sys_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [1:0] port_sel_i = 2'h0;
   logic       wr_latch_i = 1'b0;
   logic       rd_latch_i = 1'b0;
   logic       rd_pin_i = 1'b0;
   logic [7:0] bus_wdata_i = 8'h00;
   logic [7:0] bus_rdata_o;
   logic [7:0] eight_line_port_in_i, eight_line_port_out_o;
   logic [7:0] eight_line_port_oe_o, eight_line_port_pullup_o;
   logic [4:0] five_line_port_in_i, five_line_port_out_o;
   logic [4:0] five_line_port_oe_o, five_line_port_pullup_o;
   logic       uart_sync_mode_i = 1'b0, uart_rxd_out_i = 1'b1, uart_txd_out_i = 1'b1;
   logic       xmem_wr_n_i = 1'b1, xmem_rd_n_i = 1'b1, can_transmit_out_i = 1'b1;
   logic       spi_miso_out_i = 1'b1, spi_sck_out_i = 1'b1, spi_mosi_out_i = 1'b1;
   logic       uart_rxd_o, ext_interrupt_a_o, ext_interrupt_b_o, timer_a_count_in_o;
   logic       timer_b_count_in_o, spi_ss_o, can_receive_in_o;
   logic       spi_miso_o, spi_sck_o, spi_mosi_o;
   logic [7:0] ext8 = 8'h00;
   logic [4:0] ext5 = 5'h00;
   logic [7:0] l8;
   logic [4:0] l5;
   logic [31:0] r;
   int         n_mismatch = 0;
   int         samples_checked = 0;

   always #2 sys_clk_i = ~sys_clk_i;

   qbpl_ports dut_u (.sys_clk_i, .rst_i, .port_sel_i, .wr_latch_i, .rd_latch_i, .rd_pin_i,
      .bus_wdata_i, .bus_rdata_o, .eight_line_port_in_i, .eight_line_port_out_o,
      .eight_line_port_oe_o, .eight_line_port_pullup_o, .five_line_port_in_i,
      .five_line_port_out_o, .five_line_port_oe_o, .five_line_port_pullup_o,
      .uart_sync_mode_i, .uart_rxd_out_i, .uart_txd_out_i, .uart_rxd_o, .ext_interrupt_a_o,
      .ext_interrupt_b_o, .timer_a_count_in_o, .timer_b_count_in_o, .spi_ss_o, .xmem_wr_n_i,
      .xmem_rd_n_i, .can_transmit_out_i, .can_receive_in_o, .spi_miso_out_i, .spi_miso_o,
      .spi_sck_out_i, .spi_sck_o, .spi_mosi_out_i, .spi_mosi_o);

   qbpl_board board_u (.oe8_i(eight_line_port_oe_o), .ext_low8_i(ext8),
      .oe5_i(five_line_port_oe_o), .ext_low5_i(ext5),
      .pin8_o(eight_line_port_in_i), .pin5_o(five_line_port_in_i));

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // strobe stays high across back-to-back calls; caller drops it
   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      @(negedge sys_clk_i);
      port_sel_i = s;
      bus_wdata_i = d;
      wr_latch_i = 1'b1;
   endtask

   task automatic rd(input logic [1:0] s, input logic pin, output logic [7:0] d);
      @(negedge sys_clk_i);
      port_sel_i = s;
      rd_pin_i = pin;
      rd_latch_i = ~pin;
      @(negedge sys_clk_i);
      rd_pin_i = 1'b0;
      rd_latch_i = 1'b0;
      d = bus_rdata_o;
   endtask

   // transmit and write strobe drive regardless of what their latch holds
   function automatic logic [7:0] exp_oe8(input logic [7:0] a);
      logic [7:0] o;
      o = ~(a & {xmem_rd_n_i, 6'h3f, ~uart_sync_mode_i | uart_rxd_out_i});
      o[B_TXD] = ~uart_txd_out_i;
      o[B_WRS] = ~xmem_wr_n_i;
      return o;
   endfunction

   task automatic check(input logic [7:0] a, input logic [4:0] b);
      logic [7:0] o8, p8, d;
      logic [4:0] o5, p5;
      o8 = exp_oe8(a);
      o5 = ~(b & {spi_mosi_out_i, spi_sck_out_i, spi_miso_out_i, 1'b1, can_transmit_out_i});
      p8 = ~(o8 | ext8);
      p5 = ~(o5 | ext5);
      chk("oe8", o8, eight_line_port_oe_o);
      chk("oe5", {3'h0, o5}, {3'h0, five_line_port_oe_o});
      chk("pullup8", a, eight_line_port_pullup_o);
      chk("pullup5", {3'h0, b}, {3'h0, five_line_port_pullup_o});
      chk("out", 8'h00, eight_line_port_out_o | {3'h0, five_line_port_out_o});
      chk("alt8", {2'h0, p8[5] | ~a[5], p8[5] & a[5], p8[4] & a[4], p8[3] | ~a[3],
         p8[2] | ~a[2], p8[0] | ~a[0]}, {2'h0, spi_ss_o, timer_b_count_in_o,
         timer_a_count_in_o, ext_interrupt_b_o, ext_interrupt_a_o, uart_rxd_o});
      chk("alt5", {4'h0, p5[4:2], p5[1] | ~b[1]}, {4'h0, spi_mosi_o, spi_sck_o,
         spi_miso_o, can_receive_in_o});
      rd(SEL_EIGHT, 1'b0, d);
      chk("rd_latch8", a, d);
      rd(SEL_EIGHT, 1'b1, d);
      chk("rd_pin8", p8, d);
      rd(SEL_FIVE, 1'b0, d);
      chk("rd_latch5", {3'h0, b}, d);
      rd(SEL_FIVE, 1'b1, d);
      chk("rd_pin5", {3'h0, p5}, d);
      rd({1'b1, r[9]}, r[10], d);
      chk("rd_unmapped", 8'h00, d);
   endtask

   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end

   initial begin
      r = $urandom(32'ha6ae);
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      check(EIGHT_RST, FIVE_RST);
      for (int i = 0; i < 44; i++) begin
         r = $urandom();
         {uart_sync_mode_i, uart_rxd_out_i, uart_txd_out_i, xmem_wr_n_i} = r[3:0];
         {xmem_rd_n_i, can_transmit_out_i, spi_miso_out_i, spi_sck_out_i} = r[7:4];
         spi_mosi_out_i = r[8];
         ext8 = (i < 4) ? 8'h00 : r[23:16];
         ext5 = (i < 4) ? 5'h00 : r[28:24];
         l8 = (i == 1) ? 8'h00 : 8'($urandom());
         l5 = (i == 1) ? 5'h00 : 5'($urandom());
         // back-to-back writes: the last one to a port must win
         wr(SEL_EIGHT, ~l8);
         wr(SEL_EIGHT, l8);
         wr(SEL_FIVE, {3'h7, l5});
         wr({1'b1, r[11]}, 8'($urandom()));
         @(negedge sys_clk_i);
         wr_latch_i = 1'b0;
         repeat (4) @(negedge sys_clk_i);
         check(l8, l5);
         if (i == 20) begin
            rst_i = 1'b1;
            repeat (2) @(negedge sys_clk_i);
            rst_i = 1'b0;
            repeat (4) @(negedge sys_clk_i);
            check(EIGHT_RST, FIVE_RST);
         end
      end
      end_of_test();
   end
endmodule
